// file: design/mcsrc_top.sv
`include "mcsrc_cfg.svh"
module mcsrc_top (
  input  wire logic                     clock_in,
  input  wire logic                     nrst_in,
  input  wire logic                     clk_en_in,
  input  wire logic [`MCSRC_ADDR_W-1:0] avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  input  wire logic [3:0]               avs_byteenable_in,
  output logic      [31:0]              avs_readdata_out,
  output logic                          avs_waitrequest_out,
  input  wire logic                     prog_entry38_in,
  input  wire logic                     prog_entry35_in,
  input  wire logic [1:0]               cal_idx_in,
  input  wire logic                     cal_rd_in,
  output logic      [7:0]               cal_data_out,
  output logic      [9:0]               rc_trim_out,
  output logic                          clock_output_enable_out,
  output logic                          slow_mode_select_out,
  output logic      [`MCSRC_SLOW_W-1:0] slow_div_count_out,
  output logic                          cpu_tick_out,
  output logic      [1:0]               osc_src_out,
  output logic      [3:0]               osc_mult_out,
  output logic                          timer_pll_en_out,
  output logic                          timer_pre_div2_out,
  output logic                          tool_clock_out
);
  logic [7:0] main_clk_q, main_clk_d;
  logic [7:0] trim_q, trim_d;
  logic [7:0] si_q, si_d;
  logic [7:0] opt_q, opt_d;
  logic       waitreq_q, waitreq_d;
  logic [7:0] mc_wr;
  logic [7:0] opt_wr;
  logic [31:0] rdata_q, rdata_d;
  logic [`MCSRC_SLOW_W-1:0] div_q, div_d;
  logic       tick_q, tick_d;
  logic [1:0] p38_sync_q, p35_sync_q;
  mcsrc_pkg::mcsrc_prg_e prg_q, prg_d;
  mcsrc_pkg::mcsrc_sel_s sel_q, sel_d;
  mcsrc_pkg::mcsrc_opt_s opt;
  logic [7:0] cal_byte;
  logic       wr_go;
  logic       rd_go;

  function automatic logic [7:0] merge_be(input logic [7:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge_be = be[0] ? wd[7:0] : old_v;
  endfunction

  function automatic logic hit(input logic [`MCSRC_ADDR_W-1:0] a,
                               input logic [`MCSRC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Waitrequest idles high from a flop, so a new request stalls one cycle with no
  // combinational path; read data are captured in that stalled cycle so they already
  // stand when waitrequest drops and the master takes them.
  assign wr_go = avs_write_in && !waitreq_q;
  assign rd_go = avs_read_in && waitreq_q;

  always_comb begin
    waitreq_d = !((avs_read_in || avs_write_in) && waitreq_q);
    mc_wr = merge_be(main_clk_q, avs_writedata_in, avs_byteenable_in);
    opt_wr = merge_be(opt_q, avs_writedata_in, avs_byteenable_in);
    main_clk_d = main_clk_q;
    trim_d = trim_q;
    si_d = si_q;
    opt_d = opt_q;
    rdata_d = rdata_q;
    if (wr_go) begin
      if (hit(avs_address_in, `MCSRC_OFS_MAIN_CLK)) begin
        // Upper bits are held at zero in hardware as well, so a careless write is harmless.
        main_clk_d = {6'h00, mc_wr[1:0]};
      end
      if (hit(avs_address_in, `MCSRC_OFS_RC_TRIM)) begin
        trim_d = merge_be(trim_q, avs_writedata_in, avs_byteenable_in);
      end
      if (hit(avs_address_in, `MCSRC_OFS_SI_CTRL)) begin
        si_d = merge_be(si_q, avs_writedata_in, avs_byteenable_in);
      end
      if (hit(avs_address_in, `MCSRC_OFS_OPTION)) begin
        opt_d = {2'h0, opt_wr[5:0]};
      end
    end
    if (rd_go) begin
      unique case (avs_address_in)
        `MCSRC_OFS_MAIN_CLK: rdata_d = {24'h000000, main_clk_q};
        `MCSRC_OFS_RC_TRIM:  rdata_d = {24'h000000, trim_q};
        `MCSRC_OFS_SI_CTRL:  rdata_d = {24'h000000, si_q};
        `MCSRC_OFS_OPTION:   rdata_d = {24'h000000, opt_q};
        default:             rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_clk_q <= `MCSRC_MC_RESET;
      trim_q     <= `MCSRC_TRIM_RESET;
      si_q       <= `MCSRC_SI_RESET;
      opt_q      <= `MCSRC_OPT_RESET;
      waitreq_q  <= 1'b1;
      rdata_q    <= 32'h00000000;
    end else if (clk_en_in) begin
      main_clk_q <= main_clk_d;
      trim_q     <= trim_d;
      si_q       <= si_d;
      opt_q      <= opt_d;
      waitreq_q  <= waitreq_d;
      rdata_q    <= rdata_d;
    end
  end

  // Programming-entry pins come from outside the clock domain.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      p38_sync_q <= 2'b00;
      p35_sync_q <= 2'b00;
    end else if (clk_en_in) begin
      p38_sync_q <= {p38_sync_q[0], prog_entry38_in};
      p35_sync_q <= {p35_sync_q[0], prog_entry35_in};
    end
  end

  assign opt = mcsrc_pkg::mcsrc_opt_s'({opt_q[`MCSRC_OPT_SRC_HI:`MCSRC_OPT_SRC_LO],
                                        opt_q[`MCSRC_OPT_PLL_EN], opt_q[`MCSRC_OPT_PLL_X8],
                                        opt_q[`MCSRC_OPT_TPLL_EN], opt_q[`MCSRC_OPT_TDIV2]});

  always_comb begin
    prg_d = mcsrc_pkg::MCSRC_PRG_NONE;
    if (p35_sync_q[1]) begin
      prg_d = mcsrc_pkg::MCSRC_PRG_35;
    end else if (p38_sync_q[1]) begin
      prg_d = mcsrc_pkg::MCSRC_PRG_38;
    end
    sel_d = '0;
    unique case (prg_q)
      mcsrc_pkg::MCSRC_PRG_38: begin
        // Forced RC without PLL so the programming session has a known clock.
        sel_d.src = mcsrc_pkg::MCSRC_SRC_RC;
        sel_d.osc_mult = 4'h1;
      end
      mcsrc_pkg::MCSRC_PRG_35: begin
        // Options are ignored; the tool's clock enters on the external input.
        sel_d.src = mcsrc_pkg::MCSRC_SRC_EXT;
        sel_d.osc_mult = 4'h1;
        sel_d.ext_tool = 1'b1;
      end
      mcsrc_pkg::MCSRC_PRG_NONE: begin
        sel_d.src = (opt.src == mcsrc_pkg::MCSRC_SRC_RSVD) ? mcsrc_pkg::MCSRC_SRC_RC
                                                           : opt.src;
        // The PLL only takes a 1 MHz RC or external clock, never the crystal.
        sel_d.osc_mult = (opt.pll_en && sel_d.src != mcsrc_pkg::MCSRC_SRC_XTAL)
                         ? (opt.pll_x8 ? 4'h8 : 4'h4) : 4'h1;
        // Timer PLL needs 8 MHz: RC x8, or a halved ext or crystal clock.
        sel_d.tdiv2 = opt.tdiv2 && sel_d.src != mcsrc_pkg::MCSRC_SRC_RC;
        sel_d.tpll_ok = opt.tpll_en && ((sel_d.src == mcsrc_pkg::MCSRC_SRC_RC
                                         && sel_d.osc_mult == 4'h8) || sel_d.tdiv2);
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prg_q <= mcsrc_pkg::MCSRC_PRG_NONE;
      sel_q <= '0;
    end else if (clk_en_in) begin
      prg_q <= prg_d;
      sel_q <= sel_d;
    end
  end

  // Slow-mode divider produces one CPU tick every 32 cycles when selected.
  always_comb begin
    div_d = div_q + `MCSRC_SLOW_W'(1);
    tick_d = 1'b1;
    if (main_clk_q[`MCSRC_MC_SLOW_BIT]) begin
      tick_d = (div_q == `MCSRC_SLOW_W'(`MCSRC_SLOW_DIV - 1));
    end else begin
      div_d = '0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (clk_en_in) begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  mcsrc_cal_rom u_cal (
    .clock_in (clock_in),
    .en_in    (cal_rd_in && clk_en_in),
    .idx_in   (cal_idx_in),
    .data_out (cal_byte)
  );

  assign avs_waitrequest_out = waitreq_q;
  assign avs_readdata_out = rdata_q;
  assign cal_data_out = cal_byte;
  // Larger trim code means lower frequency; the oscillator takes the code unchanged.
  assign rc_trim_out = {trim_q, si_q[`MCSRC_SI_TRIM_HI:`MCSRC_SI_TRIM_LO]};
  assign clock_output_enable_out = main_clk_q[`MCSRC_MC_CKOUT_BIT];
  assign slow_mode_select_out = main_clk_q[`MCSRC_MC_SLOW_BIT];
  assign slow_div_count_out = div_q;
  assign cpu_tick_out = tick_q;
  assign osc_src_out = sel_q.src;
  assign osc_mult_out = sel_q.osc_mult;
  assign timer_pll_en_out = sel_q.tpll_ok;
  assign timer_pre_div2_out = sel_q.tdiv2;
  assign tool_clock_out = sel_q.ext_tool;
endmodule

// file: design/mcsrc_cfg.svh
`ifndef MCSRC_CFG_SVH
`define MCSRC_CFG_SVH
// Register word offsets (byte addresses, one aligned 32-bit word each).
`define MCSRC_OFS_MAIN_CLK   4'h0
`define MCSRC_OFS_RC_TRIM    4'h4
`define MCSRC_OFS_SI_CTRL    4'h8
`define MCSRC_OFS_OPTION     4'hC
`define MCSRC_ADDR_W         4
// Main clock control field positions and reset.
`define MCSRC_MC_SLOW_BIT    0
`define MCSRC_MC_CKOUT_BIT   1
`define MCSRC_MC_RESET       8'h00
// Trim register reset and lower-bit field in the system-integrity register.
`define MCSRC_TRIM_RESET     8'hFF
`define MCSRC_SI_TRIM_LO     5
`define MCSRC_SI_TRIM_HI     6
`define MCSRC_SI_RESET       8'h00
// Option word fields.
`define MCSRC_OPT_SRC_LO     0
`define MCSRC_OPT_SRC_HI     1
`define MCSRC_OPT_PLL_EN     2
`define MCSRC_OPT_PLL_X8     3
`define MCSRC_OPT_TPLL_EN    4
`define MCSRC_OPT_TDIV2      5
`define MCSRC_OPT_RESET      8'h00
// Slow-mode divider.
`define MCSRC_SLOW_DIV       32
`define MCSRC_SLOW_W         5
// Calibration store: four bytes, byte index 0..3.
`define MCSRC_CAL_DEPTH      4
`define MCSRC_CAL_FILL       8'hFF
`endif

// file: design/mcsrc_pkg.sv
package mcsrc_pkg;
  typedef enum logic [1:0] {
    MCSRC_SRC_RC,
    MCSRC_SRC_XTAL,
    MCSRC_SRC_EXT,
    MCSRC_SRC_RSVD
  } mcsrc_src_e;

  typedef enum logic [1:0] {
    MCSRC_PRG_NONE,
    MCSRC_PRG_38,
    MCSRC_PRG_35
  } mcsrc_prg_e;

  typedef struct packed {
    logic [1:0] src;
    logic       pll_en;
    logic       pll_x8;
    logic       tpll_en;
    logic       tdiv2;
  } mcsrc_opt_s;

  typedef struct packed {
    logic [1:0] src;
    logic [3:0] osc_mult;
    logic       tpll_ok;
    logic       tdiv2;
    logic       ext_tool;
  } mcsrc_sel_s;
endpackage

// file: design/mcsrc_cal_rom.sv
`include "mcsrc_cfg.svh"
module mcsrc_cal_rom (
  input  wire logic       clock_in,
  input  wire logic       en_in,
  input  wire logic [1:0] idx_in,
  output logic      [7:0] data_out
);
  // Contents are fixed at build; no write path exists, so programming cannot alter them.
  logic [7:0] mem [`MCSRC_CAL_DEPTH];
  logic [7:0] data_q;
  logic [7:0] data_d;

  initial begin
    for (int i = 0; i < `MCSRC_CAL_DEPTH; i++) begin
      mem[i] = `MCSRC_CAL_FILL;
    end
  end

  always_comb begin
    data_d = en_in ? mem[idx_in] : data_q;
  end

  always_ff @(posedge clock_in) begin
    data_q <= data_d;
  end

  assign data_out = data_q;
endmodule

// file: verification/mcsrc_top_assertions.sv
`include "mcsrc_cfg.svh"
module mcsrc_top_assertions (
  input wire logic        clock_in,
  input wire logic        nrst_in,
  input wire logic        clk_en_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        prog_entry38_in,
  input wire logic        prog_entry35_in,
  input wire logic [9:0]  rc_trim_out,
  input wire logic        clock_output_enable_out,
  input wire logic        slow_mode_select_out,
  input wire logic        cpu_tick_out,
  input wire logic [1:0]  osc_src_out,
  input wire logic        tool_clock_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in || !clk_en_in);
  logic w_ok;
  assign w_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  property p_trim_hi;
    w_ok && avs_address_in == `MCSRC_OFS_RC_TRIM
      |=> rc_trim_out[9:2] == $past(avs_writedata_in[7:0]);
  endproperty
  a_trim_hi: assert property (p_trim_hi) else $error("trim upper bits not loaded");
  property p_trim_lo;
    w_ok && avs_address_in == `MCSRC_OFS_SI_CTRL |=> rc_trim_out[1:0] == $past(avs_writedata_in[6:5]);
  endproperty
  a_trim_lo: assert property (p_trim_lo) else $error("trim lower bits not loaded");
  property p_mc_bits;
    w_ok && avs_address_in == `MCSRC_OFS_MAIN_CLK
      |=> {clock_output_enable_out, slow_mode_select_out} == $past(avs_writedata_in[1:0]);
  endproperty
  a_mc_bits: assert property (p_mc_bits) else $error("main clock bits not loaded");
  property p_rst_vals;
    $rose(nrst_in) |-> rc_trim_out == 10'h3FC && !clock_output_enable_out && !slow_mode_select_out;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_rd_trim;
    avs_read_in && !avs_waitrequest_out && avs_address_in == `MCSRC_OFS_RC_TRIM
      |-> avs_readdata_out == {24'h0, rc_trim_out[9:2]};
  endproperty
  a_rd_trim: assert property (p_rd_trim) else $error("trim readback wrong");
  property p_wait_first; $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
  property p_ack; (avs_read_in || avs_write_in) |-> ##[0:1] !avs_waitrequest_out; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_slow;
    clk_en_in && slow_mode_select_out && $past(slow_mode_select_out) && cpu_tick_out
      ##1 slow_mode_select_out
      |-> !cpu_tick_out;
  endproperty
  a_slow: assert property (p_slow) else $error("slow tick too wide");
  property p_norm;
    nrst_in && clk_en_in && !slow_mode_select_out ##1 !slow_mode_select_out |-> cpu_tick_out;
  endproperty
  a_norm: assert property (p_norm) else $error("normal tick missing");
  property p_p38; (prog_entry38_in && !prog_entry35_in)[*6] |-> osc_src_out == 2'h0; endproperty
  a_p38: assert property (p_p38) else $error("programming mode not on RC");
  property p_p35; prog_entry35_in[*6] |-> tool_clock_out; endproperty
  a_p35: assert property (p_p35) else $error("tool clock not selected");
endmodule
bind mcsrc_top mcsrc_top_assertions u_chk (.clock_in, .nrst_in, .clk_en_in, .avs_address_in,
  .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .prog_entry38_in, .prog_entry35_in, .rc_trim_out, .clock_output_enable_out,
  .slow_mode_select_out, .cpu_tick_out, .osc_src_out, .tool_clock_out);

// file: verification/mcsrc_top_tb.sv
`include "mcsrc_cfg.svh"
module mcsrc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in;
  logic        nrst_in;
  logic        cen;
  logic [4:0]  dcnt;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [3:0]  bez;
  logic        p38;
  logic        p35;
  logic [1:0]  cidx;
  logic        crd;
  logic [31:0] rdata;
  logic        waitreq;
  logic [7:0]  cal;
  logic [9:0]  trim;
  logic        ckout;
  logic        slow;
  logic        tick;
  logic [1:0]  src;
  logic [3:0]  mult;
  logic        tpll;
  logic        tdiv;
  logic        tool;
  logic [31:0] q;
  int          miscompares;
  int          cmp_count;
  // Option word, then expected {source, multiplier, timer PLL ok, halve}.
  localparam logic [15:0] opt_tab [12] = '{16'h0004, 16'h0144, 16'h0284, 16'h0410, 16'h0C20,
    16'h1C22, 16'h0EA0, 16'h3EA3, 16'h3147, 16'h1004, 16'h0304, 16'h3287};
  mcsrc_top uut (
    .clock_in(clock_in), .nrst_in(nrst_in), .clk_en_in(cen), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .prog_entry38_in(p38), .prog_entry35_in(p35), .cal_idx_in(cidx), .cal_rd_in(crd),
    .cal_data_out(cal), .rc_trim_out(trim), .clock_output_enable_out(ckout),
    .slow_mode_select_out(slow), .slow_div_count_out(dcnt), .cpu_tick_out(tick),
    .osc_src_out(src), .osc_mult_out(mult), .timer_pll_en_out(tpll),
    .timer_pre_div2_out(tdiv), .tool_clock_out(tool));
  initial begin
    clock_in = 1'h0;
    forever #12.5 clock_in = ~clock_in;
  end
  task automatic close_out;
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waitrequest and read data are sampled once settled in each cycle, so the values kept
  // are those that stand at the edge that completes the transfer.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    logic hold;
    @(posedge clock_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= bez;
    do begin
      #1;
      hold = waitreq;
      q = rdata;
      @(posedge clock_in);
    end while (hold !== 1'h0);
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic ticks(input int c, input int e);
    int k;
    k = 0;
    repeat (c) begin
      @(posedge clock_in);
      #1;
      if (tick === 1'h1) k++;
    end
    chk(32'(k), 32'(e));
  endtask
  initial begin
    #60us;
    miscompares++;
    close_out();
  end
  initial begin
    nrst_in = 1'h0; rd = 1'h0; wr = 1'h0; addr = 4'h0; wdata = 32'h0; be = 4'hF; bez = 4'hF;
    p38 = 1'h0; p35 = 1'h0; cidx = 2'h0; crd = 1'h0; miscompares = 0; cmp_count = 0;
    cen = 1'h1;
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'h1;
    rdc(`MCSRC_OFS_MAIN_CLK, 8'h00);
    rdc(`MCSRC_OFS_RC_TRIM, 8'hFF);
    chk(32'(trim), 32'h3FC);
    bus(1'h1, `MCSRC_OFS_MAIN_CLK, 8'h03);
    rdc(`MCSRC_OFS_MAIN_CLK, 8'h03);
    chk(32'({ckout, slow}), 32'h3);
    repeat (8) @(posedge clock_in);
    ticks(64, 2);
    // With the clock enable low the slow divider must hold its count.
    @(posedge clock_in);
    cen <= 1'h0;
    @(posedge clock_in);
    #1;
    q = 32'(dcnt);
    repeat (8) @(posedge clock_in);
    cen <= 1'h1;
    #1;
    chk(32'(dcnt), q);
    bus(1'h1, `MCSRC_OFS_MAIN_CLK, 8'h00);
    repeat (2) @(posedge clock_in);
    ticks(10, 10);
    bus(1'h1, `MCSRC_OFS_RC_TRIM, 8'h80);
    bus(1'h1, `MCSRC_OFS_SI_CTRL, 8'h60);
    bez = 4'hE;
    bus(1'h1, `MCSRC_OFS_RC_TRIM, 8'h11);
    bez = 4'hF;
    rdc(`MCSRC_OFS_RC_TRIM, 8'h80);
    rdc(`MCSRC_OFS_SI_CTRL, 8'h60);
    chk(32'(trim), 32'h203);
    bus(1'h1, 4'h2, 8'h55);
    rdc(4'h2, 8'h00);
    foreach (opt_tab[i]) begin
      bus(1'h1, `MCSRC_OFS_OPTION, opt_tab[i][15:8]);
      repeat (2) @(posedge clock_in);
      #1;
      chk(32'({src, mult, tpll, tdiv}), 32'(opt_tab[i][7:0]));
    end
    @(posedge clock_in);
    p38 <= 1'h1;
    repeat (6) @(posedge clock_in);
    #1;
    chk(32'(src), 32'h0);
    @(posedge clock_in);
    p35 <= 1'h1;
    repeat (6) @(posedge clock_in);
    #1;
    chk(32'(tool), 32'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_in);
      cidx <= 2'(i);
      crd <= 1'h1;
      @(posedge clock_in);
      crd <= 1'h0;
      #1;
      chk(32'(cal), 32'(`MCSRC_CAL_FILL));
    end
    @(posedge clock_in);
    nrst_in <= 1'h0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'h1;
    rdc(`MCSRC_OFS_RC_TRIM, 8'hFF);
    chk(32'(trim), 32'h3FC);
    bus(1'h1, `MCSRC_OFS_RC_TRIM, 8'h9C);
    rdc(`MCSRC_OFS_RC_TRIM, 8'h9C);
    chk(32'(trim), 32'h270);
    close_out();
  end
endmodule
